/* File: serial_dac_cfg.svh */
`ifndef SERIAL_DAC_CFG_SVH
`define SERIAL_DAC_CFG_SVH

`define SDAC_WORD_BITS      16
`define SDAC_CODE_BITS      12
`define SDAC_CODE_LSB       0
`define SDAC_MODE_LOW_POS   12
`define SDAC_MODE_HIGH_POS  13
`define SDAC_CODE_RESET     12'h000
`define SDAC_MODE_RESET     2'h0
`define SDAC_CNT_BITS       5
`define SDAC_SCLK_MAX_MHZ   30
`define SDAC_SEL_HIGH_NS    33

`endif

/* File: serial_dac_pkg.sv */
package serial_dac_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_PD_1K,
        MODE_PD_100K,
        MODE_PD_OPEN
    } op_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_DONE
    } frame_state_t;

    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic din;
    } link_pins_t;

    typedef struct packed {
        logic sclk_fall;
        logic sel_n;
        logic din;
    } link_events_t;

endpackage : serial_dac_pkg

/* File: link_sampler.sv */
`timescale 1ns/1ps
`default_nettype none

module link_sampler
(
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    // raw pins
    input  wire serial_dac_pkg::link_pins_t pins,
    // sampled events
    output var  serial_dac_pkg::link_events_t events
);

    typedef struct packed {
        serial_dac_pkg::link_pins_t   sync1;
        serial_dac_pkg::link_pins_t   sync2;
        logic                         sclk_prev;
        serial_dac_pkg::link_events_t ev;
    } samp_state_t;

    samp_state_t state_reg;
    samp_state_t state_next;

    // sync1 feeds only sync2; the edge detector looks at sync2 onward
    always_comb
    begin
        state_next              = state_reg;
        state_next.sync1        = pins;
        state_next.sync2        = state_reg.sync1;
        state_next.sclk_prev    = state_reg.sync2.sclk;
        state_next.ev.sclk_fall = state_reg.sclk_prev & ~state_reg.sync2.sclk;
        state_next.ev.sel_n     = state_reg.sync2.sel_n;
        state_next.ev.din       = state_reg.sync2.din;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            // idle levels: select high, clock high, so no false fall follows reset
            state_reg <= '{sync1: 3'h6, sync2: 3'h6, sclk_prev: 1'b1, ev: 3'h2};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign events = state_reg.ev;

endmodule : link_sampler

`default_nettype wire

/* File: serial_dac_write_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serial_dac_cfg.svh"

// Functional notes
// - sixteen-bit shift register filled per falling clock edge
// - sample data on falling serial clock only
// - serial clock up to 30 MHz
// - active-low level select; ignore clocks while high
// - select low enables shifting on falling edges
// - apply word on sixteenth falling edge
// - early select release discards partial word
// - twelve-bit straight binary code register
// - msb first: two ignored, two mode, twelve code
// - mode bits choose normal or power-down
// - reset clears code until valid frame
module serial_dac_write_port
(
    // clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           rst,
    // serial link pins
    input  wire logic                           sel_n,
    input  wire logic                           sclk,
    input  wire logic                           din,
    // converter state
    output var  logic [`SDAC_CODE_BITS-1:0]     dac_code,
    output var  serial_dac_pkg::op_mode_t       op_mode,
    output var  logic                           update_pulse
);

    typedef struct packed {
        serial_dac_pkg::frame_state_t     fsm;
        logic [`SDAC_WORD_BITS-1:0]       shift;
        logic [`SDAC_CNT_BITS-1:0]        count;
        logic [`SDAC_CODE_BITS-1:0]       code;
        serial_dac_pkg::op_mode_t         mode;
        logic                             update;
    } port_state_t;

    serial_dac_pkg::link_pins_t   pins;
    serial_dac_pkg::link_events_t ev;
    port_state_t                  state_reg;
    port_state_t                  state_next;

    assign pins = '{sel_n: sel_n, sclk: sclk, din: din};

    // 40 MHz sampling resolves edges of the 5 MHz bench clock; a 30 MHz link needs a faster clock
    link_sampler u_sampler
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pins    (pins),
        .events  (ev)
    );

    always_comb
    begin
        state_next        = state_reg;
        state_next.update = 1'b0;
        case (state_reg.fsm)
            serial_dac_pkg::ST_IDLE:
            begin
                state_next.count = '0;
                state_next.shift = '0;
                if (!ev.sel_n)
                begin
                    state_next.fsm = serial_dac_pkg::ST_SHIFT;
                end
            end
            serial_dac_pkg::ST_SHIFT:
            begin
                if (ev.sel_n)
                begin
                    // partial word dropped, outputs untouched
                    state_next.fsm = serial_dac_pkg::ST_IDLE;
                end
                else if (ev.sclk_fall)
                begin
                    state_next.shift = {state_reg.shift[`SDAC_WORD_BITS-2:0], ev.din};
                    state_next.count = state_reg.count + 5'h01;
                    if (state_reg.count == 5'(`SDAC_WORD_BITS - 1))
                    begin
                        state_next.code = state_next.shift[`SDAC_CODE_BITS-1:0];
                        state_next.mode = serial_dac_pkg::op_mode_t'(
                            state_next.shift[`SDAC_MODE_HIGH_POS:`SDAC_MODE_LOW_POS]);
                        state_next.update = 1'b1;
                        state_next.fsm    = serial_dac_pkg::ST_DONE;
                    end
                end
            end
            serial_dac_pkg::ST_DONE:
            begin
                if (ev.sel_n)
                begin
                    state_next.fsm = serial_dac_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_next.fsm = serial_dac_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg.fsm    <= serial_dac_pkg::ST_IDLE;
            state_reg.shift  <= '0;
            state_reg.count  <= '0;
            state_reg.code   <= `SDAC_CODE_RESET;
            state_reg.mode   <= serial_dac_pkg::op_mode_t'(`SDAC_MODE_RESET);
            state_reg.update <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign dac_code     = state_reg.code;
    assign op_mode      = state_reg.mode;
    assign update_pulse = state_reg.update;

endmodule : serial_dac_write_port

`default_nettype wire

/* File: serial_dac_host.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_dac_host
(
    // reference clock and link pins
    input  wire logic ref_clk,
    output var  logic sel_n,
    output var  logic sclk,
    output var  logic din
);
    initial
    begin
        sel_n = 1'b1;
        sclk  = 1'b1;
        din   = 1'b0;
    end
    // 4 ref_clk per half period: 5 MHz, far under the limit
    task automatic send(input logic [19:0] w, input int n);
        sel_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            din = w[19 - i];
            repeat (4) @(negedge ref_clk);
            sclk = 1'b0;
            repeat (4) @(negedge ref_clk);
            sclk = 1'b1;
        end
        repeat (4) @(negedge ref_clk);
        sel_n = 1'b1;
        din   = ~din; // released line must not show a stale bit
        repeat (8) @(negedge ref_clk);
    endtask : send
endmodule : serial_dac_host
`default_nettype wire

/* File: serial_dac_write_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_dac_write_port_assertions
(
    // watched ports
    input wire logic                     ref_clk,
    input wire logic                     rst,
    input wire logic                     sel_n,
    input wire logic                     sclk,
    input wire logic                     din,
    input wire logic [11:0]              dac_code,
    input wire serial_dac_pkg::op_mode_t op_mode,
    input wire logic                     update_pulse
);
    logic [4:0] falls;
    logic       sclk_q;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // raw pin count, leads the design by its sync delay
    always_ff @(posedge ref_clk)
    begin
        sclk_q <= sclk;
        if (rst || sel_n)
            falls <= 5'h00;
        else if (sclk_q && !sclk && falls != 5'h1f)
            falls <= falls + 5'h01;
    end
    pulse_once_a: assert property (update_pulse |=> !update_pulse)
        else $error("update pulse too long");
    fire_at_16_a: assert property (falls == 5'h10 && $past(falls) == 5'h0f |-> ##[1:8] update_pulse)
        else $error("no update after sixteen bits");
    only_at_16_a: assert property (update_pulse |-> falls == 5'h10)
        else $error("update at wrong bit count");
    code_hold_a: assert property (!update_pulse |-> $stable(dac_code))
        else $error("code changed without update");
    mode_hold_a: assert property (!update_pulse |-> $stable(op_mode))
        else $error("mode changed without update");
    reset_zero_a: assert property ($past(rst) |-> dac_code == 12'h000 && op_mode == 2'h0)
        else $error("outputs not cleared by reset");
    sel_quiet_a: assert property (sel_n [*8] |=> !update_pulse)
        else $error("update while deselected");
    clk_quiet_a: assert property ($stable(sclk) [*8] |=> !update_pulse)
        else $error("update without clock edge");
    cover property (update_pulse && op_mode == serial_dac_pkg::MODE_PD_OPEN);
    cover property ($rose(sel_n) && falls == 5'h0a);
    cover property (falls == 5'h14);
endmodule : serial_dac_write_port_assertions
bind serial_dac_write_port serial_dac_write_port_assertions chk (.ref_clk, .rst, .sel_n,
    .sclk, .din, .dac_code, .op_mode, .update_pulse);
`default_nettype wire

/* File: serial_dac_write_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_dac_write_port_test;
    logic                     ref_clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     sel_n, sclk, din, update_pulse;
    logic [11:0]              dac_code;
    serial_dac_pkg::op_mode_t op_mode;
    int                       num_errors = 0;
    int                       checks = 0;
    int                       pulses = 0;
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (update_pulse === 1'b1) pulses++;
    serial_dac_host host (.ref_clk, .sel_n, .sclk, .din);
    serial_dac_write_port dut (.ref_clk, .rst, .sel_n, .sclk, .din, .dac_code, .op_mode,
        .update_pulse);
    task automatic chk(input logic [11:0] c, input logic [1:0] m, input int p);
        checks++;
        if ({dac_code, op_mode, pulses} !== {c, m, p})
        begin
            num_errors++;
            $display("unexpected state exp %h %h %0d seen %h %h %0d", c, m, p,
                dac_code, op_mode, pulses);
        end
    endtask : chk
    task automatic t_modes;
        logic [11:0] c [4] = '{12'h000, 12'hfff, 12'h5a3, 12'ha5c};
        for (int m = 0; m < 4; m++)
        begin
            host.send({2'b11, m[1:0], c[m], 4'h0}, 16);
            chk(c[m], m[1:0], m + 1);
        end
    endtask : t_modes
    task automatic t_abort;
        host.send({16'h2123, 4'h0}, 10);
        chk(12'ha5c, 2'h3, 4);
        host.send({16'h1321, 4'h0}, 16);
        chk(12'h321, 2'h1, 5);
    endtask : t_abort
    task automatic t_extra;
        host.send({16'h2abc, 4'hf}, 20);
        chk(12'habc, 2'h2, 6);
    endtask : t_extra
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        chk(12'h000, 2'h0, 0);
        t_modes();
        t_abort();
        t_extra();
        stop_test();
    end
endmodule : serial_dac_write_port_test
`default_nettype wire
